// *** rtl/isf_interrupt_status_flags.sv ***
`include "isf_defs.svh"
`default_nettype none
module isf_interrupt_status_flags
    import isf_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = `ISF_WDOG_CYC,
    parameter int unsigned GPIO_N      = 12
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire isf_src_t          src,
    input  wire logic              rxFifoWrite,
    input  wire logic              rxFifoFull,
    input  wire logic [GPIO_N-1:0] gpioPin,
    output logic                   rxFifoWriteEn,
    output logic                   macResetActive,
    output logic [GPIO_N-1:0]      gpioWakeClear,
    output logic                   irqOut
);
    logic [GPIO_N-1:0] gpioMeta_q;
    logic [GPIO_N-1:0] gpioSync_q;
    logic              gpioPrimed_q;
    logic [31:0]       status_q;
    logic [31:0]       mask_q;
    logic [1:0]        ctrl_q;
    logic [2:0]        irqSts_q;
    logic [2:0]        irqMask_q;
    logic [31:0]       wdogCnt_q;
    isf_rst_state_t    rstState_q;
    logic              rtoPulse;
    logic [31:0]       setVec;
    logic [31:0]       clrVec;
    logic              wrAcc;
    logic              rdAcc;
    logic              mapped;
    logic [31:0]       rdData;

    // only the completing access cycle acts, so a write or read clear lands exactly once
    assign wrAcc = psel & penable & pready & pwrite;
    assign rdAcc = psel & penable & pready & ~pwrite;
    assign mapped = (paddr == `ISF_OFF_STATUS) || (paddr == `ISF_OFF_MASK)
                 || (paddr == `ISF_OFF_CTRL) || (paddr == `ISF_OFF_IRQSTS)
                 || (paddr == `ISF_OFF_IRQMASK);
    assign clrVec = (wrAcc && paddr == `ISF_OFF_STATUS) ? (pwdata & `ISF_WRITABLE)
                                                       : 32'h0;

    // pins are asynchronous, so two flops before any use
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gpioMeta_q <= '0;
            gpioSync_q <= '0;
        end else begin
            gpioMeta_q <= gpioPin;
            gpioSync_q <= gpioMeta_q;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q    <= 2'h0;
            mask_q    <= 32'h0;
            irqMask_q <= 3'h0;
        end else if (wrAcc) begin
            if (paddr == `ISF_OFF_CTRL) ctrl_q <= pwdata[1:0];
            if (paddr == `ISF_OFF_MASK) mask_q <= pwdata & `ISF_WRITABLE;
            if (paddr == `ISF_OFF_IRQMASK) irqMask_q <= pwdata[2:0];
        end
    end

    // watchdog covers the MAC reset; PHY clocks missing means it expires
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstState_q <= ISF_RST_IDLE;
            wdogCnt_q  <= 32'h0;
        end else begin
            unique case (rstState_q)
                ISF_RST_IDLE: begin
                    wdogCnt_q <= 32'h0;
                    if (ctrl_q[`ISF_CTRL_MACRST]) rstState_q <= ISF_RST_WAIT;
                end
                ISF_RST_WAIT: begin
                    if (src.phyRxClkSeen && src.phyTxClkSeen) begin
                        rstState_q <= ISF_RST_IDLE;
                    end else if (wdogCnt_q == WDOG_CYCLES - 1) begin
                        rstState_q <= ISF_RST_TOUT;
                    end else begin
                        wdogCnt_q <= wdogCnt_q + 32'h1;
                    end
                end
                ISF_RST_TOUT: begin
                    if (!ctrl_q[`ISF_CTRL_MACRST]) rstState_q <= ISF_RST_IDLE;
                end
                default: rstState_q <= ISF_RST_IDLE;
            endcase
        end
    end

    assign rtoPulse = (rstState_q == ISF_RST_WAIT) && !(src.phyRxClkSeen && src.phyTxClkSeen)
                   && (wdogCnt_q == WDOG_CYCLES - 1);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) macResetActive <= 1'b0;
        else macResetActive <= (rstState_q == ISF_RST_WAIT);
    end

    always_comb begin
        setVec = 32'h0;
        setVec[`ISF_BIT_RXLPI]  = src.rxLowPowerIdle;
        setVec[`ISF_BIT_MACRTO] = rtoPulse;
        setVec[`ISF_BIT_RXOVF]  = rxFifoWrite & rxFifoFull;
        setVec[`ISF_BIT_TXERR]  = src.transmitError;
        setVec[`ISF_BIT_USB]    = |src.usbEvents;
        setVec[`ISF_BIT_TXDIS]  = src.fifoTxDisabled | src.macTxDisabled;
        setVec[`ISF_BIT_RXDIS]  = src.fifoRxDisabled | src.macRxDisabled;
        setVec[`ISF_BIT_PHY]    = src.transceiverIrq;
        setVec[`ISF_BIT_DP]     = src.dataPortDone;
        setVec[`ISF_BIT_MACERR] = |src.macErrors;
        setVec[GPIO_N-1:0]      = gpioSync_q;
    end

    // set beats clear so an event in the clearing cycle survives
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_q     <= 32'h0;
            gpioPrimed_q <= 1'b0;
        end else begin
            status_q <= (status_q & ~clrVec) | setVec;
            if (!gpioPrimed_q) begin
                status_q[GPIO_N-1:0] <= gpioSync_q;
                gpioPrimed_q         <= 1'b1;
            end
            if (!ctrl_q[`ISF_CTRL_EEE]) status_q[`ISF_BIT_RXLPI] <= 1'b0;
            status_q[14:13] <= 2'b00;
            status_q[`ISF_BIT_UTXFP] <= src.usbTxFramePending;
            status_q[31:25] <= 7'h0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxFifoWriteEn <= 1'b0;
            gpioWakeClear <= '0;
        end else begin
            rxFifoWriteEn <= rxFifoWrite & ~rxFifoFull & ~status_q[`ISF_BIT_RXOVF];
            gpioWakeClear <= clrVec[GPIO_N-1:0];
        end
    end

    // summary events: any unmasked flag, watchdog expiry, and any bus error; read clears
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqSts_q <= 3'h0;
        end else begin
            if (rdAcc && paddr == `ISF_OFF_IRQSTS) irqSts_q <= 3'h0;
            if (|(status_q & mask_q)) irqSts_q[0] <= 1'b1;
            if (rtoPulse) irqSts_q[1] <= 1'b1;
            if (psel && penable && pready && !mapped) irqSts_q[2] <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) irqOut <= 1'b0;
        else irqOut <= |(irqSts_q & irqMask_q);
    end

    always_comb begin
        unique case (paddr)
            `ISF_OFF_STATUS:  rdData = status_q;
            `ISF_OFF_MASK:    rdData = mask_q;
            `ISF_OFF_CTRL:    rdData = {30'h0, ctrl_q};
            `ISF_OFF_IRQSTS:  rdData = {29'h0, irqSts_q};
            `ISF_OFF_IRQMASK: rdData = {29'h0, irqMask_q};
            default:          rdData = 32'h0;
        endcase
    end

    // one wait state: ready rises in the second access cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata  <= (psel & penable & ~pready & ~pwrite) ? rdData : 32'h0;
        end
    end
endmodule : isf_interrupt_status_flags
`default_nettype wire

// *** pkg/isf_defs.svh ***
// Function
// - receive low-power-idle pulse sets bit 24.
// - bit 24 held at zero while energy-efficient enable is off.
// - 8 ms watchdog during MAC reset pulses bit 23 on expiry.
// - MAC reset released once the watchdog has expired.
// - write into a full RX FIFO sets overflow bit 22.
// - while overflow is flagged, new receive data is discarded.
// - transmit error level sets bit 21.
// - bit 20 set by USB status events, held until all cleared.
// - bit 19 set on TX disable, held while either TX-disabled bit set.
// - bit 18 set on RX disable, held while either RX-disabled bit set.
// - bit 17 reflects PHY interrupt level until cleared in the PHY.
// - data port completion pulse sets bit 16.
// - bit 15 set by MAC errors, held until all error bits clear.
// - bit 12 is read-only live frame-pending indication, resets zero.
// - bits 11:0 are level GPIO flags, reset value follows the pins.
// - clearing a GPIO flag also clears that GPIO's wake event.
`ifndef ISF_DEFS_SVH
`define ISF_DEFS_SVH
`define ISF_OFF_STATUS   12'h00c
`define ISF_OFF_MASK     12'h040
`define ISF_OFF_CTRL     12'h044
`define ISF_OFF_IRQSTS   12'h048
`define ISF_OFF_IRQMASK  12'h04c
`define ISF_BIT_RXLPI    24
`define ISF_BIT_MACRTO   23
`define ISF_BIT_RXOVF    22
`define ISF_BIT_TXERR    21
`define ISF_BIT_USB      20
`define ISF_BIT_TXDIS    19
`define ISF_BIT_RXDIS    18
`define ISF_BIT_PHY      17
`define ISF_BIT_DP       16
`define ISF_BIT_MACERR   15
`define ISF_BIT_UTXFP    12
`define ISF_CTRL_EEE     0
`define ISF_CTRL_MACRST  1
`define ISF_WDOG_MS      8
`define ISF_CLK_HZ       20000000
`define ISF_WDOG_CYC     ((`ISF_WDOG_MS * `ISF_CLK_HZ) / 1000)
`define ISF_WRITABLE     32'h01ff8fff
`endif

// *** pkg/isf_pkg.sv ***
`default_nettype none
package isf_pkg;
    typedef struct packed {
        logic        rxLowPowerIdle;
        logic        transmitError;
        logic [15:0] usbEvents;
        logic        fifoTxDisabled;
        logic        macTxDisabled;
        logic        fifoRxDisabled;
        logic        macRxDisabled;
        logic        transceiverIrq;
        logic        dataPortDone;
        logic [15:0] macErrors;
        logic        usbTxFramePending;
        logic        phyRxClkSeen;
        logic        phyTxClkSeen;
    } isf_src_t;
    typedef enum logic [1:0] {
        ISF_RST_IDLE  = 2'b00,
        ISF_RST_WAIT  = 2'b01,
        ISF_RST_TOUT  = 2'b10
    } isf_rst_state_t;
endpackage : isf_pkg
`default_nettype wire

// *** verification/isf_checker.sv ***
`default_nettype none
module isf_checker
    import isf_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = 20,
    parameter int unsigned GPIO_N      = 12
) (
    input wire logic              core_clk,
    input wire logic              reset_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              rxFifoWrite,
    input wire logic              rxFifoFull,
    input wire logic              rxFifoWriteEn,
    input wire logic              macResetActive,
    input wire logic [GPIO_N-1:0] gpioWakeClear
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic [31:0] rstCnt_q;
    // watchdog length is a parameter, so a counter replaces a long repetition
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) rstCnt_q <= '0;
        else rstCnt_q <= macResetActive ? rstCnt_q + 32'h1 : '0;
    end
    sequence setup_s; psel && !penable; endsequence
    sequence access_s; psel && penable; endsequence
    ready_wait_a: assert property (setup_s ##1 access_s |=> pready) else $error("ready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    unmapped_err_a: assert property (pready && !(paddr inside {12'h00c, 12'h040, 12'h044,
        12'h048, 12'h04c}) |-> pslverr && prdata == 32'h0) else $error("unmapped accepted");
    reserved_zero_a: assert property (pready && !pwrite && paddr == 12'h00c |->
        prdata[14:13] == 2'b00) else $error("reserved bits set");
    ovf_block_a: assert property (rxFifoWrite && rxFifoFull |=>
        !rxFifoWriteEn [*2]) else $error("write allowed after overflow");
    wdog_bound_a: assert property (rstCnt_q <= WDOG_CYCLES + 4) else $error("reset stuck");
    wake_cause_a: assert property (|gpioWakeClear |->
        $past(psel && pwrite && paddr == 12'h00c)) else $error("wake clear without write");
    wake_pulse_a: assert property (|gpioWakeClear |=> gpioWakeClear == '0) else $error("long wake");
endmodule : isf_checker
bind isf_interrupt_status_flags isf_checker #(.WDOG_CYCLES(WDOG_CYCLES), .GPIO_N(GPIO_N))
    u_isf_checker (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxFifoWrite(rxFifoWrite), .rxFifoFull(rxFifoFull), .rxFifoWriteEn(rxFifoWriteEn),
    .macResetActive(macResetActive), .gpioWakeClear(gpioWakeClear));
`default_nettype wire

// *** verification/tb_interrupt_status_flags.sv ***
`default_nettype none
module tb_interrupt_status_flags import isf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned WDOG = 20;
    localparam logic [31:0] LVL_BITS [6] = '{32'h00200000, 32'h00100000, 32'h00080000,
                                             32'h00040000, 32'h00020000, 32'h00008000};
    logic        core_clk = 1'b0;
    logic        reset_n, psel, penable, pwrite, pready, pslverr, errB, irqA;
    logic        rxFifoWrite, rxFifoFull, rxFifoWriteEn, macResetActive, irqOut;
    logic [11:0] paddr, gpioPin, gpioWakeClear;
    logic [31:0] pwdata, prdata, rd;
    isf_src_t    src, s;
    int          error_cnt, total_checks, n, k;
    int          seed = 32'h08fed762;
    always #25 core_clk = ~core_clk;
    isf_interrupt_status_flags #(.WDOG_CYCLES(WDOG)) u_isf_interrupt_status_flags (
        .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src(src), .rxFifoWrite(rxFifoWrite), .rxFifoFull(rxFifoFull),
        .gpioPin(gpioPin), .rxFifoWriteEn(rxFifoWriteEn), .macResetActive(macResetActive),
        .gpioWakeClear(gpioWakeClear), .irqOut(irqOut));
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            error_cnt++;
            complete_run();
        end else begin
            rd = prdata;
            errB = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task automatic pulse(input isf_src_t p);
        @(posedge core_clk);
        src <= p;
        @(posedge core_clk);
        src <= '0;
    endtask : pulse
    // level sources, vectors and the tx/rx disable pair drawn at random
    function automatic isf_src_t lvl(input int i, input logic [31:0] r);
        isf_src_t v;
        v = '0;
        case (i)
            0: v.transmitError = 1'b1;
            1: v.usbEvents = r[15:0] | 16'h0001;
            2: {v.fifoTxDisabled, v.macTxDisabled} = r[0] ? 2'b10 : 2'b01;
            3: {v.fifoRxDisabled, v.macRxDisabled} = r[0] ? 2'b10 : 2'b01;
            4: v.transceiverIrq = 1'b1;
            default: v.macErrors = r[31:16] | 16'h0001;
        endcase
        return v;
    endfunction : lvl
    initial begin
        reset_n = 1'b0;
        {psel, penable, pwrite, rxFifoWrite, rxFifoFull} = '0;
        paddr = '0;
        pwdata = '0;
        src = '0;
        gpioPin = 12'ha5c;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rdchk(12'h00c, 32'h00000a5c);
        gpioPin <= 12'h000;
        repeat (4) @(posedge core_clk);
        apb(1'b1, 12'h00c, 32'hffffffff);
        @(posedge core_clk);
        chk({20'h0, gpioWakeClear}, 32'h00000fff);
        rdchk(12'h00c, 32'h0);
        rdchk(12'h100, 32'h0);
        chk({31'h0, errB}, 32'h1);
        s = '0;
        s.usbTxFramePending = 1'b1;
        src <= s;
        apb(1'b1, 12'h00c, 32'h00001000);
        rdchk(12'h00c, 32'h00001000);
        src <= '0;
        rdchk(12'h00c, 32'h0);
        apb(1'b1, 12'h044, 32'h1);
        s = '0;
        {s.rxLowPowerIdle, s.dataPortDone} = 2'b11;
        pulse(s);
        rdchk(12'h00c, 32'h01010000);
        apb(1'b1, 12'h00c, 32'h01010000);
        rdchk(12'h00c, 32'h0);
        apb(1'b1, 12'h044, 32'h0);
        pulse(s);
        rdchk(12'h00c, 32'h00010000);
        apb(1'b1, 12'h00c, 32'h00010000);
        for (k = 0; k < 6; k++) begin
            src <= lvl(k, $random(seed));
            repeat (3) @(posedge core_clk);
            rdchk(12'h00c, LVL_BITS[k]);
            apb(1'b1, 12'h00c, LVL_BITS[k]);
            rdchk(12'h00c, LVL_BITS[k]);
            src <= '0;
            apb(1'b1, 12'h00c, LVL_BITS[k]);
            rdchk(12'h00c, 32'h0);
        end
        {rxFifoWrite, rxFifoFull} <= 2'b11;
        @(posedge core_clk);
        // keep writing into a non-full fifo so only the overflow flag can block
        {rxFifoWrite, rxFifoFull} <= 2'b10;
        repeat (3) @(posedge core_clk);
        chk({31'h0, rxFifoWriteEn}, 32'h0);
        rdchk(12'h00c, 32'h00400000);
        apb(1'b1, 12'h00c, 32'h00400000);
        repeat (2) @(posedge core_clk);
        chk({31'h0, rxFifoWriteEn}, 32'h1);
        apb(1'b1, 12'h044, 32'h2);
        repeat (3) @(posedge core_clk);
        chk({31'h0, macResetActive}, 32'h1);
        for (n = 0; macResetActive !== 1'b0 && n < 60; n++) @(posedge core_clk);
        chk({31'h0, macResetActive}, 32'h0);
        rdchk(12'h00c, 32'h00800000);
        apb(1'b1, 12'h04c, 32'h1);
        apb(1'b1, 12'h040, 32'h0);
        repeat (2) @(posedge core_clk);
        irqA = irqOut;
        apb(1'b1, 12'h040, 32'h01ffffff);
        repeat (3) @(posedge core_clk);
        chk({30'h0, irqA, irqOut}, 32'h1);
        apb(1'b0, 12'h048, 32'h0);
        chk(rd & 32'h2, 32'h2);
        apb(1'b0, 12'h048, 32'h0);
        chk(rd & 32'h2, 32'h0);
        complete_run();
    end
endmodule : tb_interrupt_status_flags
`default_nettype wire
